// File: design/prs_core.sv
// Reset, bus request, parity/system error and stop handling for the bus
//
// Function
// RULE_01: Drive own point-to-point bus request when needing bus
// RULE_02: Host reset clears all registers and state machines
// RULE_03: Host reset floats all outputs immediately, asynchronously
// RULE_04: Power-down mode: reset only from auxiliary supply
// RULE_05: Parity error line never used for special cycles
// RULE_06: System error line reports special-cycle and serious errors
// RULE_07: Target stop ends the current master transaction
// RULE_08: Arbiter grant tells device it owns bus
`timescale 1ns/10ps
module prs_core (
  input wire logic i_clk, // Bus clock, 20 MHz
  input wire logic i_rst_n, // Host reset or aux supply good, async
  input wire logic i_pd_mode, // Strap: power-down-enable configuration
  input wire logic i_need_bus, // Core wants bus ownership
  input wire logic i_data_par_err, // Data parity error detected, pulse
  input wire logic i_special_cycle, // Current transaction is special cycle
  input wire logic i_addr_par_err, // Error warranting system attention
  input wire logic i_stop_req, // Core as target asks master to stop
  input wire logic i_bus_grant_line_n, // Grant from arbiter
  input wire logic i_target_stop_line_n, // Stop line as seen on bus
  output logic o_bus_request_line_n, // Request to arbiter
  output logic o_bus_request_line_oe, // Request driver enable
  output logic o_data_parity_error_line_n, // Parity error line value
  output logic o_data_parity_error_line_oe, // Parity error driver enable
  output logic o_system_error_line_n, // Open-drain value, always low
  output logic o_system_error_line_oe, // Open-drain pull enable
  output logic o_target_stop_line_n, // Stop line value
  output logic o_target_stop_line_oe, // Stop line driver enable
  output logic o_test_pins_oe, // Boundary-scan output enable
  output logic o_granted, // Core owns the bus
  output logic o_master_stop, // One-cycle: end master transaction now
  output logic o_pd_mode // Latched configuration strap
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] gnt_sync_q; // Grant synchroniser, bit 0 is first stage
  logic [1:0] stop_sync_q; // Stop synchroniser, bit 0 is first stage
  prs_pkg::mst_state_type st_q; // Master request state
  prs_pkg::mst_state_type st_d;
  logic req_q; // Registered request level
  logic req_d;
  logic mstop_q; // Registered stop pulse for the core
  logic mstop_d;
  logic perr_q; // Registered parity error drive
  logic perr_d;
  logic serr_q; // Registered system error pull
  logic serr_d;
  logic tstop_q; // Registered target stop drive
  logic tstop_d;
  logic pd_q; // Configuration strap capture
  logic pd_d;
  logic strap_done_q; // Strap already taken since release
  logic strap_done_d;
  logic gnt_seen; // Grant after the second stage
  logic stop_seen; // Stop after the second stage

  // Active-low line helper: true when the level is asserted
  function automatic logic line_on(input logic lvl);
    line_on = (lvl == prs_pkg::PIN_ACTIVE);
  endfunction

  assign gnt_seen = line_on(gnt_sync_q[1]);
  assign stop_seen = line_on(stop_sync_q[1]);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Only the second stage is read by any logic
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gnt_sync_q <= prs_pkg::SYNC_IDLE; // [RULE_02]
      stop_sync_q <= prs_pkg::SYNC_IDLE; // [RULE_02]
    end else begin
      gnt_sync_q <= {gnt_sync_q[0], i_bus_grant_line_n};
      stop_sync_q <= {stop_sync_q[0], i_target_stop_line_n};
    end
  end

  // ----------------------------------------------------------------
  // Master request state machine, next values
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    req_d = 1'h0;
    mstop_d = 1'h0;
    case (st_q)
      // Nothing pending
      prs_pkg::M_IDLE: begin
        if (i_need_bus) begin
          st_d = prs_pkg::M_REQ;
          req_d = 1'h1; // [RULE_01]
        end
      end
      // Request raised, waiting for the arbiter
      prs_pkg::M_REQ: begin
        if (!i_need_bus) begin
          st_d = prs_pkg::M_IDLE;
        end else if (gnt_seen) begin
          st_d = prs_pkg::M_OWN; // [RULE_08]
          req_d = 1'h1;
        end else begin
          req_d = 1'h1; // [RULE_01]
        end
      end
      // Bus owned; a target stop ends the transaction
      prs_pkg::M_OWN: begin
        if (stop_seen) begin
          st_d = prs_pkg::M_IDLE;
          mstop_d = 1'h1; // [RULE_07]
        end else if (!i_need_bus) begin
          st_d = prs_pkg::M_IDLE;
        end else begin
          req_d = 1'h1;
        end
      end
      default: begin
        st_d = prs_pkg::M_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Error and stop drive, next values
  // ----------------------------------------------------------------
  // Special-cycle parity errors go to the system error line instead,
  // because no single agent owns a broadcast's data phase
  always_comb begin
    perr_d = i_data_par_err && !i_special_cycle; // [RULE_05]
    serr_d = i_addr_par_err ||
             (i_data_par_err && i_special_cycle); // [RULE_06]
    tstop_d = i_stop_req; // [RULE_07]
    pd_d = pd_q;
    strap_done_d = 1'h1;
    if (!strap_done_q) begin
      pd_d = i_pd_mode; // Strap is caught once, after release
    end
  end

  // ----------------------------------------------------------------
  // All state registers except the pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= prs_pkg::M_IDLE; // [RULE_02]
      req_q <= 1'h0;
      mstop_q <= 1'h0;
      perr_q <= 1'h0;
      serr_q <= 1'h0;
      tstop_q <= 1'h0;
      pd_q <= 1'h0;
      strap_done_q <= 1'h0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      mstop_q <= mstop_d;
      perr_q <= perr_d;
      serr_q <= serr_d;
      tstop_q <= tstop_d;
      pd_q <= pd_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Enables are gated straight by the reset pin so the bus floats with
  // no clock edge; in power-down mode that pin is the aux supply good
  // level, so only a power-up clears the block [RULE_04]
  assign o_bus_request_line_n = req_q ? prs_pkg::PIN_ACTIVE
                                      : prs_pkg::PIN_IDLE; // [RULE_01]
  assign o_bus_request_line_oe = i_rst_n ? prs_pkg::OE_ON
                                         : prs_pkg::OE_OFF; // [RULE_03]
  assign o_data_parity_error_line_n = perr_q ? prs_pkg::PIN_ACTIVE
                                             : prs_pkg::PIN_IDLE;
  assign o_data_parity_error_line_oe = (i_rst_n && perr_q) ? prs_pkg::OE_ON
                                       : prs_pkg::OE_OFF; // [RULE_03]
  assign o_system_error_line_n = prs_pkg::PIN_ACTIVE;
  assign o_system_error_line_oe = (i_rst_n && serr_q) ? prs_pkg::OE_ON
                                  : prs_pkg::OE_OFF; // [RULE_06]
  assign o_target_stop_line_n = tstop_q ? prs_pkg::PIN_ACTIVE
                                        : prs_pkg::PIN_IDLE;
  assign o_target_stop_line_oe = (i_rst_n && tstop_q) ? prs_pkg::OE_ON
                                 : prs_pkg::OE_OFF; // [RULE_03]
  assign o_test_pins_oe = i_rst_n ? prs_pkg::OE_ON
                                  : prs_pkg::OE_OFF; // [RULE_03]
  assign o_granted = (st_q == prs_pkg::M_OWN);
  assign o_master_stop = mstop_q;
  assign o_pd_mode = pd_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_want_idle;
    i_need_bus && (st_q == prs_pkg::M_IDLE);
  endsequence

  sequence s_stop_hit;
    (st_q == prs_pkg::M_OWN) && stop_seen;
  endsequence

  property p_req_raise;
    s_want_idle |=> line_on(o_bus_request_line_n) && o_bus_request_line_oe;
  endproperty
  a_req_raise: assert property (p_req_raise) // [RULE_01]
    else $error("request not raised after need");

  property p_req_own_only;
    !i_need_bus |=> !line_on(o_bus_request_line_n);
  endproperty
  a_req_own_only: assert property (p_req_own_only) // [RULE_01]
    else $error("request held without need");

  property p_release_clean;
    $rose(strap_done_q) |-> $past(st_q) == prs_pkg::M_IDLE && !$past(req_q);
  endproperty
  a_release_clean: assert property (p_release_clean) // [RULE_02]
    else $error("state not initial after reset");

  // Checked while reset is low, so the module-wide reset disable is
  // overridden here; otherwise the check could never fire
  property p_float_in_reset;
    @(negedge i_clk) disable iff (1'b0)
      !i_rst_n |-> !o_bus_request_line_oe && !o_test_pins_oe
      && !o_data_parity_error_line_oe && !o_target_stop_line_oe
      && !o_system_error_line_oe;
  endproperty
  a_float_in_reset: assert property (p_float_in_reset) // [RULE_03]
    else $error("output driven during reset");

  property p_strap_hold;
    strap_done_q |=> $stable(o_pd_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // [RULE_04]
    else $error("strap changed after capture");

  property p_perr_special;
    i_data_par_err && i_special_cycle |=> !o_data_parity_error_line_oe
      && o_system_error_line_oe;
  endproperty
  a_perr_special: assert property (p_perr_special) // [RULE_05]
    else $error("special cycle error on wrong line");

  property p_serr_report;
    (i_addr_par_err || (i_data_par_err && i_special_cycle))
      |=> o_system_error_line_oe ##1 !$past(i_addr_par_err)
      && !$past(i_data_par_err) |-> !o_system_error_line_oe;
  endproperty
  a_serr_report: assert property (p_serr_report) // [RULE_06]
    else $error("system error not reported");

  property p_stop_ends;
    s_stop_hit |=> o_master_stop && !o_granted ##1 !o_master_stop;
  endproperty
  a_stop_ends: assert property (p_stop_ends) // [RULE_07]
    else $error("target stop did not end transaction");

endmodule

// File: design/prs_pkg.sv
// Shared constants for the host-bus reset, request, error and stop block
package prs_pkg;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  localparam logic PIN_ACTIVE = 1'h0; // Bus control lines are active low
  localparam logic PIN_IDLE = 1'h1; // Deasserted level of a bus line
  localparam logic OE_ON = 1'h1; // Module drives the pin
  localparam logic OE_OFF = 1'h0; // Pin floats

  // ----------------------------------------------------------------
  // Synchroniser shape
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2; // Flip-flops before logic reads a pin
  localparam logic [1:0] SYNC_IDLE = 2'h3; // Reset value of a sync chain

  // ----------------------------------------------------------------
  // Master request states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE,
    M_REQ,
    M_OWN
  } mst_state_type;

endpackage

// File: dv/prs_arb_model.sv
// Behavioural arbiter and remote target on the far side of the bus block
`timescale 1ns/10ps
module prs_arb_model (
  input wire logic i_clk, // Bus clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_req_n, // Request pin value from the block
  input wire logic i_req_oe, // Request pin enable from the block
  input wire logic i_stop_cmd, // Bench asks this target to stop
  input wire logic [3:0] i_delay, // Grant latency in cycles
  output logic o_gnt_n, // Grant to the block, active low
  output logic o_stop_n // Stop drive; released reads as pulled up
);
  // ----------------------------------------------------------------
  // Grant and stop
  // ----------------------------------------------------------------
  logic [3:0] cnt_q; // Cycles the request has waited so far
  // Signals change only just after an edge, as a real agent would
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      o_gnt_n <= 1'h1;
      o_stop_n <= 1'h1;
    end else begin
      o_stop_n <= !i_stop_cmd;
      if (i_req_oe && !i_req_n) begin
        if (cnt_q >= i_delay) o_gnt_n <= 1'h0;
        else cnt_q <= cnt_q + 4'h1;
      end else begin
        // Grant withdrawn as soon as the request drops
        cnt_q <= 4'h0;
        o_gnt_n <= 1'h1;
      end
    end
  end
endmodule

// File: dv/tb_pci_reset_request_error_signals.sv
// Self-checking bench for the bus reset, request, error and stop block
`timescale 1ns/10ps
module tb_pci_reset_request_error_signals;
  // ----------------------------------------------------------------
  // Stimulus, wires and helpers
  // ----------------------------------------------------------------
  logic i_clk = 0, i_rst_n = 0, pd = 0, need = 0, dpe = 0, spc = 0;
  logic ape = 0, sreq = 0, scmd = 0, is_dpe;
  logic [3:0] dly = 4'h2; // Arbiter latency, drawn at random
  logic [1:0] cp, cs; // Cycles seen on parity and system error lines
  logic gnt_n, target_stop_line_n, stop_bus_n, req_n, req_oe, pe_n, pe_oe;
  logic se_n, se_oe, ts_n, ts_oe, tp_oe, granted, mstop, pdq;
  int err_count = 0;
  int checked = 0;
  always #25 i_clk = ~i_clk; // 20 MHz
  // Wired stop line: low if either party pulls it, else pulled up
  assign stop_bus_n = target_stop_line_n & !(ts_oe && !ts_n);
  prs_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pd_mode(pd),
    .i_need_bus(need), .i_data_par_err(dpe), .i_special_cycle(spc),
    .i_addr_par_err(ape), .i_stop_req(sreq), .i_bus_grant_line_n(gnt_n),
    .i_target_stop_line_n(stop_bus_n), .o_bus_request_line_n(req_n),
    .o_bus_request_line_oe(req_oe), .o_data_parity_error_line_n(pe_n),
    .o_data_parity_error_line_oe(pe_oe), .o_system_error_line_n(se_n),
    .o_system_error_line_oe(se_oe), .o_target_stop_line_n(ts_n),
    .o_target_stop_line_oe(ts_oe), .o_test_pins_oe(tp_oe),
    .o_granted(granted), .o_master_stop(mstop), .o_pd_mode(pdq));
  prs_arb_model arb (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_n(req_n),
    .i_req_oe(req_oe), .i_stop_cmd(scmd), .i_delay(dly),
    .o_gnt_n(gnt_n), .o_stop_n(target_stop_line_n));
  // Four-state compare so an unknown never passes
  task chk(string n, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Sample just after the edge, once its updates have landed
  task tick;
    @(posedge i_clk);
    #1;
  endtask
  // Expected {parity pulses, system error pulses} for one event
  function logic [7:0] exp_err(logic d, logic s);
    if (d && !s) return 8'h04;
    return 8'h01;
  endfunction
  task report_and_stop;
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(56898));
    pd = 1'($urandom % 2);
    repeat (10) @(negedge i_clk);
    chk("oe_reset", 8'h00, {req_oe, pe_oe, se_oe, ts_oe, tp_oe});
    chk("granted_reset", 8'h00, {granted, mstop, pdq});
    i_rst_n = 1;
    tick;
    chk("pd_mode", {7'h00, pd}, {7'h00, pdq});
    // Strap moves after capture; the captured value must not follow it
    @(negedge i_clk);
    pd = !pd;
    tick;
    chk("pd_hold", {7'h00, !pd}, {7'h00, pdq});
    // Error events; the first two force both cycle kinds
    for (int i = 0; i < 24; i++) begin
      @(negedge i_clk);
      is_dpe = (i < 2) ? 1'b1 : 1'($urandom % 2);
      spc = (i < 2) ? 1'(i) : 1'($urandom % 2);
      dpe = is_dpe;
      ape = !is_dpe;
      cp = 2'h0;
      cs = 2'h0;
      repeat (2) begin
        tick;
        cp = cp + 2'(pe_oe && !pe_n);
        cs = cs + 2'(se_oe && !se_n);
        @(negedge i_clk);
        dpe = 0;
        ape = 0;
      end
      chk("err", exp_err(is_dpe, spc), {4'h0, cp, cs});
    end
    // Block as target asks the master to stop
    sreq = 1;
    tick;
    chk("tstop_on", 8'h02, {6'h00, ts_oe, ts_n});
    @(negedge i_clk);
    sreq = 0;
    tick;
    chk("tstop_off", 8'h00, {7'h00, ts_oe});
    // Request, grant after random latency, then remote stop
    repeat (3) begin
      @(negedge i_clk);
      dly = 4'($urandom % 8);
      need = 1;
      for (int k = 0; k < 3 && req_n !== 1'b0; k++) tick;
      chk("request", 8'h01, {6'h00, req_n, req_oe});
      for (int k = 0; k < 16 && granted !== 1'b1; k++) tick;
      chk("granted", 8'h01, {7'h00, granted});
      @(negedge i_clk);
      scmd = 1;
      for (int k = 0; k < 6 && mstop !== 1'b1; k++) tick;
      chk("mstop_on", 8'h02, {6'h00, mstop, granted});
      @(negedge i_clk);
      scmd = 0;
      need = 0;
      tick;
      chk("mstop_pulse", 8'h00, {7'h00, mstop});
      repeat (6) tick;
    end
    // Own the bus and drive stop, then reset mid-run: all must clear
    // before any clock edge. Reset lands before our own stop loops back.
    @(negedge i_clk);
    need = 1;
    for (int k = 0; k < 16 && granted !== 1'b1; k++) tick;
    @(negedge i_clk);
    sreq = 1;
    tick;
    chk("pre_reset", 8'h03, {6'h00, granted, ts_oe});
    @(negedge i_clk);
    i_rst_n = 0;
    #1;
    chk("oe_async", 8'h00, {req_oe, pe_oe, se_oe, ts_oe, tp_oe});
    chk("state_async", 8'h00, {granted, mstop});
    @(negedge i_clk);
    need = 0;
    sreq = 0;
    // Second release: idle request, no grant, strap taken again
    @(negedge i_clk);
    i_rst_n = 1;
    tick;
    chk("release", 8'h06, {5'h00, req_n, req_oe, granted});
    chk("pd_again", {7'h00, pd}, {7'h00, pdq});
    report_and_stop;
  end
  // Whole run is under 200 cycles; give it far more before cutting off
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
endmodule
